// file: verilog/integer_pipeline_hazard_control.sv
// integer pipeline hazard control: interlocks, issue timing, forwarding, register bank
// assumes the load/store unit reports misses, slot fills and per-register load completion
`timescale 1ns/1ps
`default_nettype none

module integer_pipeline_hazard_control
   import hz_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // decode stage
   input wire decode_t i_dec,
   output logic o_dec_stall,
   output logic o_dec_advance,
   output logic o_fold,
   // execute and memory results
   input wire logic [XLEN-1:0] i_ex_result,
   input wire logic [XLEN-1:0] i_mem_alu_result,
   input wire logic [XLEN-1:0] i_mem_load_data,
   // load_store_pipeline status
   input wire logic i_lsu_multi_busy,
   input wire logic i_load_miss,
   input wire logic i_miss_fill,
   input wire logic [NUM_REGS-1:0] i_ldm_loaded,
   // register bank write ports
   input wire wr_port_t i_wr_alu,
   input wire wr_port_t i_wr_load1,
   input wire wr_port_t i_wr_load2,
   // operands
   output logic [XLEN-1:0] o_opnd_a,
   output logic [XLEN-1:0] o_opnd_b,
   output logic [XLEN-1:0] o_store_data1,
   output logic [XLEN-1:0] o_store_data2,
   // pipeline status
   output logic o_ex_stall,
   output logic o_pipe_stall,
   output stage_t o_ex_stage,
   output stage_t o_mem_stage,
   output logic o_mul_flags_pending,
   output logic o_miss_slot_busy,
   output logic [NUM_REGS-1:0] o_ldm_pending
);

   // ==========================================================
   // state and nets
   stage_t ex_q;
   stage_t mem_q;
   logic miss_valid;
   logic [REG_W-1:0] miss_dst;
   logic [NUM_REGS-1:0] ldm_pend;
   logic [REG_W-1:0] mul_dst;
   logic [XLEN-1:0] bank [NUM_REGS];
   wr_port_t wr [NUM_WR];
   logic [NUM_REGS-1:0] late_mask;
   logic [NUM_REGS-1:0] early_mask;
   logic [CYC_W-1:0] cyc;
   logic dep_stall;
   logic hw_stall;
   logic freeze;
   logic advance;
   logic [NUM_CNT-1:0] cnt_start;
   logic [CYC_W-1:0] cnt_load [NUM_CNT];
   logic [NUM_CNT-1:0] cnt_busy;
   logic [REG_W-1:0] rd_src [NUM_RD];
   logic [NUM_RD-1:0] rd_use;
   stage_t rd_near [NUM_RD];
   fwd_t rd_sel [NUM_RD];

   // ==========================================================
   // helpers
   // beats spent on the list below the program counter
   function automatic logic [CYC_W-1:0] list_beats(input decode_t d);
      logic [CYC_W-1:0] n;
      n = '0;
      for (int i = 0; i < PC_REG; i++)
      begin
         n = n + {{(CYC_W-1){1'b0}}, d.reg_list[i]};
      end
      if (d.aligned64)
      begin
         return n >> 1;
      end
      return (n == '0) ? '0 : CYC_ONE + ((n - CYC_ONE) >> 1);
   endfunction : list_beats

   function automatic logic [CYC_W-1:0] issue_cycles(input decode_t d);
      unique case (d.op)
         MULTIPLY_OP: return MUL_ISSUE_CYC;
         CALL_PREFIX_OP: return CALL_PREFIX_CYC;
         CALL_EXCHANGE_OP: return CALL_TARGET_CYC;
         BRANCH_OP: return d.folded ? BR_FOLD_CYC : (d.buf_empty ? BR_EMPTY_CYC : BR_PLAIN_CYC);
         SOFTWARE_INTERRUPT_OP: return d.cond_pass ? SWI_PASS_CYC : SWI_FAIL_CYC;
         POP_PC_OP: return list_beats(d) + POP_PC_EXTRA;
         LOAD_OP, STORE_OP: return LS_ISSUE_CYC;
         default: return LS_ISSUE_CYC;
      endcase
   endfunction : issue_cycles

   function automatic stage_t to_stage(input decode_t d);
      stage_t s;
      s.valid = d.valid;
      s.op = d.op;
      s.dst = (d.op == CALL_PREFIX_OP) ? LINK_REG : d.dst;
      s.wr = d.wr_dst || (d.op == CALL_PREFIX_OP);
      s.src_s = d.src_s;
      s.src_s2 = d.src_s2;
      s.use_s = d.use_s;
      s.use_s2 = d.use_s2;
      s.use_acc = d.use_acc;
      return s;
   endfunction : to_stage

   function automatic logic [XLEN-1:0] bank_read(input logic [REG_W-1:0] r);
      logic [XLEN-1:0] v;
      v = bank[r];
      for (int i = 0; i < NUM_WR; i++)
      begin
         if (wr[i].en && wr[i].idx == r)
         begin
            v = wr[i].data;
         end
      end
      return v;
   endfunction : bank_read

   function automatic logic [XLEN-1:0] pick(input fwd_t s, input logic [XLEN-1:0] b);
      unique case (s)
         FWD_EX: return i_ex_result;
         FWD_MEM_ALU: return i_mem_alu_result;
         FWD_MEM_LOAD: return i_mem_load_data;
         FWD_BANK: return b;
      endcase
   endfunction : pick

   // ==========================================================
   // register bank
   // load ports first, ALU port last
   assign wr[0] = i_wr_load1;
   assign wr[1] = i_wr_load2;
   assign wr[2] = i_wr_alu;

   always_ff @(posedge i_core_clk)
   begin
      for (int i = 0; i < NUM_WR; i++)
      begin
         if (wr[i].en)
         begin
            bank[wr[i].idx] <= wr[i].data;
         end
      end
   end

   // ==========================================================
   // hazard masks
   // load and multiply destinations still in flight
   always_comb
   begin
      late_mask = ldm_pend;
      if (miss_valid)
      begin
         late_mask[miss_dst] = 1'b1;
      end
      if (mem_q.valid && mem_q.wr && is_load(mem_q.op) && i_load_miss)
      begin
         late_mask[mem_q.dst] = 1'b1;
      end
      if (cnt_busy[CNT_MUL_RD])
      begin
         late_mask[mul_dst] = 1'b1;
      end
      early_mask = late_mask;
      if (ex_q.valid && ex_q.wr && is_load(ex_q.op))
      begin
         early_mask[ex_q.dst] = 1'b1;
      end
   end

   always_comb
   begin
      dep_stall = (i_dec.use_a && early_mask[i_dec.src_a])
         || (i_dec.use_b && early_mask[i_dec.src_b])
         || (i_dec.use_s && !i_dec.use_acc && late_mask[i_dec.src_s])
         || (i_dec.use_s2 && late_mask[i_dec.src_s2]);
   end

   always_comb
   begin
      hw_stall = 1'b0;
      if (is_load(i_dec.op) && i_lsu_multi_busy)
      begin
         hw_stall = 1'b1;
      end
      if (is_load(i_dec.op) && i_dec.wr_dst && miss_valid && miss_dst == i_dec.dst)
      begin
         hw_stall = 1'b1;
      end
      if (i_dec.op == MULTIPLY_OP && cnt_busy[CNT_MUL_STAGE])
      begin
         hw_stall = 1'b1;
      end
      if (cnt_busy[CNT_ISSUE])
      begin
         hw_stall = 1'b1;
      end
   end

   assign o_pipe_stall = i_load_miss && miss_valid && !i_miss_fill;
   assign o_ex_stall = ex_q.valid && ex_q.use_acc && late_mask[ex_q.src_s];
   assign freeze = o_pipe_stall || o_ex_stall;
   assign o_dec_stall = i_dec.valid && (dep_stall || hw_stall || freeze);
   assign advance = i_dec.valid && !o_dec_stall;
   assign o_dec_advance = advance;
   assign cyc = issue_cycles(i_dec);
   assign o_fold = advance && (cyc == '0);

   // ==========================================================
   // issue and multiplier timing
   always_comb
   begin
      cnt_start[CNT_ISSUE] = advance;
      cnt_load[CNT_ISSUE] = (cyc == '0) ? '0 : cyc - CYC_ONE;
      for (int i = CNT_MUL_STAGE; i < NUM_CNT; i++)
      begin
         cnt_start[i] = advance && (i_dec.op == MULTIPLY_OP);
      end
      cnt_load[CNT_MUL_STAGE] = MUL_ISSUE_CYC - CYC_ONE;
      cnt_load[CNT_MUL_RD] = MUL_RD_CYC - CYC_ONE;
      cnt_load[CNT_MUL_FLAG] = MUL_FLAG_CYC - CYC_ONE;
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CNT; g++)
      begin : g_cnt
         hz_cycle_count u_cnt (
            .i_core_clk(i_core_clk),
            .i_nrst(i_nrst),
            .i_start(cnt_start[g]),
            .i_load(cnt_load[g]),
            .o_busy(cnt_busy[g])
         );
      end
   endgenerate

   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
      begin
         mul_dst <= '0;
      end
      else if (cnt_start[CNT_MUL_RD])
      begin
         mul_dst <= i_dec.dst;
      end
   end

   assign o_mul_flags_pending = cnt_busy[CNT_MUL_FLAG];

   // ==========================================================
   // stage tracking
   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
      begin
         ex_q <= '0;
         mem_q <= '0;
      end
      else if (!freeze)
      begin
         ex_q <= (advance && cyc != '0) ? to_stage(i_dec) : '0;
         mem_q <= ex_q;
      end
   end

   // set wins over the fill that frees the slot
   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
      begin
         miss_valid <= 1'b0;
         miss_dst <= '0;
      end
      else if (i_load_miss && (!miss_valid || i_miss_fill))
      begin
         miss_valid <= 1'b1;
         miss_dst <= mem_q.dst;
      end
      else if (i_miss_fill)
      begin
         miss_valid <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
      begin
         ldm_pend <= '0;
      end
      else
      begin
         ldm_pend <= (ldm_pend & ~i_ldm_loaded)
            | ((advance && is_load(i_dec.op) && i_dec.op != LOAD_OP) ? i_dec.reg_list : '0);
      end
   end

   // ==========================================================
   // read ports and forwarding
   // ports A and B from Decode
   always_comb
   begin
      rd_src[PORT_A] = i_dec.src_a;
      rd_src[PORT_B] = i_dec.src_b;
      rd_src[PORT_S1] = ex_q.src_s;
      rd_src[PORT_S2] = ex_q.src_s2;
      rd_use[PORT_A] = i_dec.use_a;
      rd_use[PORT_B] = i_dec.use_b;
      rd_use[PORT_S1] = ex_q.valid && ex_q.use_s;
      rd_use[PORT_S2] = ex_q.valid && ex_q.use_s2;
      rd_near[PORT_A] = ex_q;
      rd_near[PORT_B] = ex_q;
      rd_near[PORT_S1] = '0;
      rd_near[PORT_S2] = '0;
   end

   generate
      for (g = 0; g < NUM_RD; g++)
      begin : g_fwd
         hz_fwd_sel u_fwd (
            .i_src(rd_src[g]),
            .i_use(rd_use[g]),
            .i_near(rd_near[g]),
            .i_far(mem_q),
            .o_sel(rd_sel[g])
         );
      end
   endgenerate

   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
      begin
         o_opnd_a <= '0;
         o_opnd_b <= '0;
      end
      else if (advance)
      begin
         o_opnd_a <= pick(rd_sel[PORT_A], bank_read(rd_src[PORT_A]));
         o_opnd_b <= pick(rd_sel[PORT_B], bank_read(rd_src[PORT_B]));
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
      begin
         o_store_data1 <= '0;
         o_store_data2 <= '0;
      end
      else if (!freeze)
      begin
         o_store_data1 <= pick(rd_sel[PORT_S1], bank_read(rd_src[PORT_S1]));
         o_store_data2 <= pick(rd_sel[PORT_S2], bank_read(rd_src[PORT_S2]));
      end
   end

   assign o_ex_stage = ex_q;
   assign o_mem_stage = mem_q;
   assign o_miss_slot_busy = miss_valid;
   assign o_ldm_pending = ldm_pend;

endmodule : integer_pipeline_hazard_control

`default_nettype wire

// file: verilog/hz_pkg.sv
// shared types, field layouts and cycle figures for integer pipeline hazard control
// assumes a 16-entry register bank and one core clock
package hz_pkg;

   // ==========================================================
   // widths and register numbers
   localparam int REG_W = 4;
   localparam int NUM_REGS = 16;
   localparam int XLEN = 32;
   localparam int CYC_W = 5;
   localparam logic [REG_W-1:0] LINK_REG = 4'hE;
   localparam int PC_REG = 15;

   // ==========================================================
   // issue and result cycle figures
   localparam logic [CYC_W-1:0] CYC_ONE = 5'h01;
   localparam logic [CYC_W-1:0] MUL_ISSUE_CYC = 5'h04;
   localparam logic [CYC_W-1:0] MUL_RD_CYC = 5'h03;
   localparam logic [CYC_W-1:0] MUL_FLAG_CYC = 5'h04;
   localparam logic [CYC_W-1:0] CALL_PREFIX_CYC = 5'h01;
   localparam logic [CYC_W-1:0] CALL_TARGET_CYC = 5'h04;
   localparam logic [CYC_W-1:0] BR_FOLD_CYC = 5'h00;
   localparam logic [CYC_W-1:0] BR_EMPTY_CYC = 5'h02;
   localparam logic [CYC_W-1:0] BR_PLAIN_CYC = 5'h01;
   localparam logic [CYC_W-1:0] SWI_PASS_CYC = 5'h04;
   localparam logic [CYC_W-1:0] SWI_FAIL_CYC = 5'h02;
   localparam logic [CYC_W-1:0] LS_ISSUE_CYC = 5'h01;
   localparam logic [CYC_W-1:0] POP_PC_EXTRA = 5'h06;

   // ==========================================================
   // counter slots and read port slots
   localparam int CNT_ISSUE = 0;
   localparam int CNT_MUL_STAGE = 1;
   localparam int CNT_MUL_RD = 2;
   localparam int CNT_MUL_FLAG = 3;
   localparam int NUM_CNT = 4;
   localparam int PORT_A = 0;
   localparam int PORT_B = 1;
   localparam int PORT_S1 = 2;
   localparam int PORT_S2 = 3;
   localparam int NUM_RD = 4;
   localparam int NUM_WR = 3;

   // ==========================================================
   // types
   typedef enum logic [3:0] {
      NONE_OP = 4'h0,
      ALU_OP = 4'h1,
      MULTIPLY_OP = 4'h2,
      LOAD_OP = 4'h3,
      STORE_OP = 4'h4,
      LOAD_MULTIPLE_OP = 4'h5,
      STORE_MULTIPLE_OP = 4'h6,
      POP_PC_OP = 4'h7,
      BRANCH_OP = 4'h8,
      CALL_PREFIX_OP = 4'h9,
      CALL_EXCHANGE_OP = 4'hA,
      SOFTWARE_INTERRUPT_OP = 4'hB
   } op_t;

   typedef enum logic [1:0] {
      FWD_BANK = 2'h0,
      FWD_EX = 2'h1,
      FWD_MEM_ALU = 2'h2,
      FWD_MEM_LOAD = 2'h3
   } fwd_t;

   typedef struct packed {
      logic valid;
      op_t op;
      logic [REG_W-1:0] src_a;
      logic [REG_W-1:0] src_b;
      logic [REG_W-1:0] src_s;
      logic [REG_W-1:0] src_s2;
      logic [REG_W-1:0] dst;
      logic use_a;
      logic use_b;
      logic use_s;
      logic use_s2;
      logic use_acc;
      logic wr_dst;
      logic cond_pass;
      logic folded;
      logic buf_empty;
      logic aligned64;
      logic [NUM_REGS-1:0] reg_list;
   } decode_t;

   typedef struct packed {
      logic valid;
      op_t op;
      logic [REG_W-1:0] dst;
      logic wr;
      logic [REG_W-1:0] src_s;
      logic [REG_W-1:0] src_s2;
      logic use_s;
      logic use_s2;
      logic use_acc;
   } stage_t;

   typedef struct packed {
      logic en;
      logic [REG_W-1:0] idx;
      logic [XLEN-1:0] data;
   } wr_port_t;

   // instructions whose result comes back through the load ports
   function automatic logic is_load(input op_t op);
      return (op == LOAD_OP) || (op == LOAD_MULTIPLE_OP) || (op == POP_PC_OP);
   endfunction : is_load

endpackage : hz_pkg

// file: verilog/hz_cycle_count.sv
// down counter that stays busy for a loaded number of cycles
// assumes the caller loads one less than the total occupancy
`timescale 1ns/1ps
`default_nettype none

module hz_cycle_count
   import hz_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // load
   input wire logic i_start,
   input wire logic [CYC_W-1:0] i_load,
   // status
   output logic o_busy
);

   logic [CYC_W-1:0] left;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
      begin
         left <= '0;
      end
      else if (i_start)
      begin
         left <= i_load;
      end
      else if (left != '0)
      begin
         left <= left - CYC_ONE;
      end
   end

   assign o_busy = (left != '0);

endmodule : hz_cycle_count

`default_nettype wire

// file: verilog/hz_fwd_sel.sv
// forwarding source choice for one register read port
// assumes near is one stage younger than far in the pipeline
`timescale 1ns/1ps
`default_nettype none

module hz_fwd_sel
   import hz_pkg::*;
(
   // source operand
   input wire logic [REG_W-1:0] i_src,
   input wire logic i_use,
   // in-flight producers
   input wire stage_t i_near,
   input wire stage_t i_far,
   // choice
   output var fwd_t o_sel
);

   always_comb
   begin
      o_sel = FWD_BANK;
      if (i_use && i_near.valid && i_near.wr && !is_load(i_near.op) && i_near.dst == i_src)
      begin
         o_sel = FWD_EX;
      end
      else if (i_use && i_far.valid && i_far.wr && i_far.dst == i_src)
      begin
         o_sel = is_load(i_far.op) ? FWD_MEM_LOAD : FWD_MEM_ALU;
      end
   end

endmodule : hz_fwd_sel

`default_nettype wire

// file: test/hazard_monitor.sv
// concurrent checks on the hazard control ports
// assumes it is bound onto the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module hazard_monitor
   import hz_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire decode_t i_dec,
   input wire logic o_dec_stall,
   input wire logic o_dec_advance,
   input wire logic o_fold,
   input wire logic i_lsu_multi_busy,
   input wire logic i_load_miss,
   input wire logic i_miss_fill,
   input wire logic o_pipe_stall,
   input wire logic o_mul_flags_pending,
   input wire logic o_miss_slot_busy,
   input wire logic [NUM_REGS-1:0] o_ldm_pending
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);

   // ==========================================================
   // helper logic
   logic ld_fresh;
   logic [REG_W-1:0] ld_dst;
   wire logic adv_mul = o_dec_advance && (i_dec.op == MULTIPLY_OP);
   wire logic adv_swi = o_dec_advance && (i_dec.op == SOFTWARE_INTERRUPT_OP);
   wire logic adv_call = o_dec_advance && (i_dec.op == CALL_EXCHANGE_OP);
   wire logic adv_br = o_dec_advance && (i_dec.op == BRANCH_OP);

   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
      begin
         ld_fresh <= 1'b0;
         ld_dst <= 4'h0;
      end
      else
      begin
         ld_fresh <= o_dec_advance && (i_dec.op == LOAD_OP) && i_dec.wr_dst;
         ld_dst <= i_dec.dst;
      end
   end

   // ==========================================================
   // assertions
   a_adv_means_free: assert property (o_dec_advance == (i_dec.valid && !o_dec_stall))
      else $error("advance disagrees with stall");
   a_mul_issue_hold: assert property (adv_mul |=> !o_dec_advance [*3])
      else $error("multiply issue too short");
   a_mul_flag_time: assert property (adv_mul |=> o_mul_flags_pending [*3] ##1 !o_mul_flags_pending)
      else $error("multiply flag timing wrong");
   a_call_target_hold: assert property (adv_call |=> !o_dec_advance [*3])
      else $error("call target too short");
   a_swi_pass_hold: assert property (adv_swi && i_dec.cond_pass |=> !o_dec_advance [*3])
      else $error("swi pass too short");
   a_swi_fail_hold: assert property (adv_swi && !i_dec.cond_pass |=> !o_dec_advance)
      else $error("swi fail too short");
   a_fold_only_branch: assert property (o_fold |-> adv_br && i_dec.folded)
      else $error("fold without folded branch");
   a_empty_branch_hold: assert property (adv_br && !i_dec.folded && i_dec.buf_empty |=> !o_dec_advance)
      else $error("empty buffer branch too short");
   a_load_use_stall: assert property (ld_fresh && i_dec.valid && i_dec.use_a && (i_dec.src_a == ld_dst) |-> o_dec_stall)
      else $error("load use not stalled");
   a_ldm_reg_wait: assert property (i_dec.valid && i_dec.use_a && o_ldm_pending[i_dec.src_a] |-> o_dec_stall)
      else $error("pending register read");
   a_multi_busy_load: assert property (i_dec.valid && (i_dec.op == LOAD_OP) && i_lsu_multi_busy |-> o_dec_stall)
      else $error("load during multiple transfer");
   a_miss_slot_stall: assert property (i_load_miss && o_miss_slot_busy && !i_miss_fill |-> o_pipe_stall)
      else $error("second miss not stalled");

   c_mul: cover property (adv_mul);
   c_fold: cover property (o_fold);
   c_pipe_stall: cover property (o_pipe_stall);
endmodule : hazard_monitor

bind integer_pipeline_hazard_control hazard_monitor mon (.i_core_clk, .i_nrst, .i_dec,
   .o_dec_stall, .o_dec_advance, .o_fold, .i_lsu_multi_busy, .i_load_miss, .i_miss_fill,
   .o_pipe_stall, .o_mul_flags_pending, .o_miss_slot_busy, .o_ldm_pending);

`default_nettype wire

// file: test/lsu_partner_model.sv
// behavioural load/store unit: misses, miss slot fills, multiple-load completion
// assumes the bench arms misses; fills and per-register loads come after fixed delays
`timescale 1ns/1ps
`default_nettype none

module lsu_partner_model
   import hz_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_miss_arm,
   input wire stage_t i_mem_stage,
   input wire logic i_slot_busy,
   input wire logic [NUM_REGS-1:0] i_pending,
   output logic o_load_miss,
   output logic o_miss_fill,
   output logic o_multi_busy,
   output logic [NUM_REGS-1:0] o_loaded
);
   logic [2:0] fcnt;
   logic [2:0] lcnt;

   // miss held until the pipeline moves the load on
   assign o_load_miss = i_miss_arm && i_mem_stage.valid && (i_mem_stage.op == LOAD_OP);
   assign o_multi_busy = |i_pending;

   always_ff @(posedge i_core_clk)
   begin
      o_miss_fill <= i_nrst && i_slot_busy && (fcnt == 3'h4);
      if (!i_nrst || !i_slot_busy || (fcnt == 3'h4))
         fcnt <= 3'h0;
      else
         fcnt <= fcnt + 3'h1;
   end

   // one register loaded every fourth cycle, lowest first
   always_ff @(posedge i_core_clk)
   begin
      o_loaded <= (i_nrst && (lcnt == 3'h3)) ? (i_pending & (~i_pending + 16'h0001)) : 16'h0000;
      if (!i_nrst || !o_multi_busy || (lcnt == 3'h3))
         lcnt <= 3'h0;
      else
         lcnt <= lcnt + 3'h1;
   end
endmodule : lsu_partner_model

`default_nettype wire

// file: test/integer_pipeline_hazard_control_bench.sv
// self-checking bench for integer pipeline hazard control
// assumes the load/store partner model and the bound monitor
`timescale 1ns/1ps
`default_nettype none

module integer_pipeline_hazard_control_bench
   import hz_pkg::*;
();
   logic clk, nrst, arm;
   decode_t dec;
   wr_port_t wa, wl1, wl2;
   logic [XLEN-1:0] exr, malr, mldr, oa, ob, sd1, sd2;
   logic stall, adv, fold, exst, pst, flg, slot, miss, fill, mbusy;
   logic [NUM_REGS-1:0] pend, ldd;
   stage_t exs, mems;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;

   integer_pipeline_hazard_control uut (.i_core_clk(clk), .i_nrst(nrst), .i_dec(dec),
      .o_dec_stall(stall), .o_dec_advance(adv), .o_fold(fold), .i_ex_result(exr),
      .i_mem_alu_result(malr), .i_mem_load_data(mldr), .i_lsu_multi_busy(mbusy),
      .i_load_miss(miss), .i_miss_fill(fill), .i_ldm_loaded(ldd), .i_wr_alu(wa),
      .i_wr_load1(wl1), .i_wr_load2(wl2), .o_opnd_a(oa), .o_opnd_b(ob), .o_store_data1(sd1),
      .o_store_data2(sd2), .o_ex_stall(exst), .o_pipe_stall(pst), .o_ex_stage(exs),
      .o_mem_stage(mems), .o_mul_flags_pending(flg), .o_miss_slot_busy(slot),
      .o_ldm_pending(pend));

   lsu_partner_model lsu (.i_core_clk(clk), .i_nrst(nrst), .i_miss_arm(arm), .i_mem_stage(mems),
      .i_slot_busy(slot), .i_pending(pend), .o_load_miss(miss), .o_miss_fill(fill),
      .o_multi_busy(mbusy), .o_loaded(ldd));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         n_fail++;
         give_verdict();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [XLEN-1:0] seen, input logic [XLEN-1:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   function automatic decode_t mk(op_t op, logic [REG_W-1:0] a, logic ua, logic [REG_W-1:0] d);
      decode_t r;
      r = '0;
      r.valid = 1'b1;
      r.op = op;
      r.src_a = a;
      r.use_a = ua;
      r.dst = d;
      r.wr_dst = (op == ALU_OP) || (op == LOAD_OP) || (op == MULTIPLY_OP);
      return r;
   endfunction : mk

   // present one instruction, count stalled cycles until it is taken
   task automatic send(input decode_t d, output int st, output logic fl);
      dec = d;
      st = 0;
      #1;
      while (adv !== 1'b1 && st < 40)
      begin
         @(negedge clk);
         st++;
         #1;
      end
      fl = fold;
      @(negedge clk);
   endtask : send

   task automatic idle(input int n);
      dec = '0;
      repeat (n) @(negedge clk);
   endtask : idle

   // stall cycles seen by an independent follower
   task automatic t_issue(input decode_t d, input int exp);
      int st;
      logic fl;
      send(d, st, fl);
      send(mk(ALU_OP, 4'h0, 1'b0, 4'h0), st, fl);
      check(XLEN'(st), XLEN'(exp));
   endtask : t_issue

   // ==========================================================
   // scenarios
   task automatic sc_timing();
      decode_t d;
      int st;
      logic fl;
      t_issue(mk(MULTIPLY_OP, 4'h1, 1'b1, 4'h2), 3);
      t_issue(mk(CALL_PREFIX_OP, 4'h0, 1'b0, LINK_REG), 0);
      t_issue(mk(CALL_EXCHANGE_OP, LINK_REG, 1'b1, 4'h0), 3);
      d = mk(SOFTWARE_INTERRUPT_OP, 4'h0, 1'b0, 4'h0);
      d.cond_pass = 1'b1;
      t_issue(d, 3);
      d.cond_pass = 1'b0;
      t_issue(d, 1);
      t_issue(mk(STORE_OP, 4'h1, 1'b1, 4'h0), 0);
      t_issue(mk(LOAD_OP, 4'h1, 1'b1, 4'h3), 0);
      d = mk(BRANCH_OP, 4'h0, 1'b0, 4'h0);
      d.buf_empty = 1'b1;
      t_issue(d, 1);
      d.buf_empty = 1'b0;
      d.folded = 1'b1;
      send(d, st, fl);
      check(XLEN'(fl), 32'h00000001);
      send(mk(ALU_OP, 4'h0, 1'b0, 4'h0), st, fl);
      check(XLEN'(st), 32'h00000000);
      d = mk(POP_PC_OP, 4'h1, 1'b1, 4'h0);
      d.reg_list = 16'h800E;
      d.aligned64 = 1'b1;
      t_issue(d, 6);
      d.aligned64 = 1'b0;
      t_issue(d, 7);
      idle(40);
   endtask : sc_timing

   task automatic sc_forward();
      decode_t d;
      int st;
      logic fl;
      send(mk(ALU_OP, 4'h0, 1'b0, 4'h4), st, fl);
      send(mk(ALU_OP, 4'h4, 1'b1, 4'h5), st, fl);
      check(XLEN'(st), 32'h00000000);
      check(oa, exr);
      send(mk(ALU_OP, 4'h0, 1'b0, 4'h8), st, fl);
      send(mk(ALU_OP, 4'h0, 1'b0, 4'h9), st, fl);
      send(mk(ALU_OP, 4'h8, 1'b1, 4'h6), st, fl);
      check(oa, malr);
      send(mk(LOAD_OP, 4'h1, 1'b1, 4'hA), st, fl);
      send(mk(ALU_OP, 4'hA, 1'b1, 4'h6), st, fl);
      check(XLEN'(st), 32'h00000001);
      check(oa, mldr);
      send(mk(LOAD_OP, 4'h1, 1'b1, 4'hB), st, fl);
      d = mk(STORE_OP, 4'h1, 1'b1, 4'h0);
      d.src_s = 4'hB;
      d.use_s = 1'b1;
      send(d, st, fl);
      check(XLEN'(st), 32'h00000000);
      idle(1);
      check(sd1, mldr);
      send(mk(LOAD_OP, 4'h1, 1'b1, 4'hC), st, fl);
      send(mk(STORE_OP, 4'hC, 1'b1, 4'h0), st, fl);
      check(XLEN'(st), 32'h00000001);
      idle(4);
   endtask : sc_forward

   task automatic sc_bank();
      decode_t d;
      int st;
      logic fl;
      wa = '{1'b1, 4'h7, 32'hAAAA0001};
      wl1 = '{1'b1, 4'h7, 32'h55550002};
      @(negedge clk);
      wa.en = 1'b0;
      wl1.en = 1'b0;
      wl2 = '{1'b1, 4'h8, 32'h0F0F0003};
      d = mk(ALU_OP, 4'h7, 1'b1, 4'h0);
      d.src_b = 4'h8;
      d.use_b = 1'b1;
      send(d, st, fl);
      wl2.en = 1'b0;
      check(XLEN'(st), 32'h00000000);
      check(oa, 32'hAAAA0001);
      check(ob, 32'h0F0F0003);
      idle(2);
   endtask : sc_bank

   task automatic sc_ldm();
      decode_t d;
      decode_t m;
      int st;
      logic fl;
      d = mk(LOAD_MULTIPLE_OP, 4'h1, 1'b1, 4'h0);
      d.reg_list = 16'h0008;
      m = mk(MULTIPLY_OP, 4'h0, 1'b0, 4'h2);
      m.src_s = 4'h3;
      m.use_s = 1'b1;
      m.use_acc = 1'b1;
      send(d, st, fl);
      send(m, st, fl);
      check(XLEN'(st), 32'h00000000);
      check(XLEN'(exst), 32'h00000001);
      send(mk(ALU_OP, 4'h3, 1'b1, 4'h9), st, fl);
      check(XLEN'(st >= 3), 32'h00000001);
      send(d, st, fl);
      send(mk(LOAD_OP, 4'h1, 1'b1, 4'h9), st, fl);
      check(XLEN'(st >= 3), 32'h00000001);
      idle(10);
   endtask : sc_ldm

   task automatic sc_miss();
      int st;
      logic fl;
      logic seen;
      seen = 1'b0;
      arm = 1'b1;
      send(mk(LOAD_OP, 4'h1, 1'b1, 4'h9), st, fl);
      send(mk(LOAD_OP, 4'h1, 1'b1, 4'hA), st, fl);
      dec = '0;
      repeat (12)
      begin
         @(negedge clk);
         if (pst === 1'b1)
            seen = 1'b1;
      end
      arm = 1'b0;
      check(XLEN'(seen), 32'h00000001);
      repeat (12) @(negedge clk);
      check(XLEN'(slot), 32'h00000000);
   endtask : sc_miss

   // ==========================================================
   // main sequence
   initial
   begin
      nrst = 1'b0;
      arm = 1'b0;
      dec = '0;
      wa = '0;
      wl1 = '0;
      wl2 = '0;
      exr = 32'h00001234;
      malr = 32'h00005678;
      mldr = 32'hA5A50001;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      sc_timing();
      sc_forward();
      sc_bank();
      sc_ldm();
      sc_miss();
      give_verdict();
   end
endmodule : integer_pipeline_hazard_control_bench

`default_nettype wire
